// ### shared/cst_pkg.sv
// constants, field positions and state types of the can status broadcaster
package cst_pkg;
   // -------------------------------------------------
   // timing
   // -------------------------------------------------
   localparam int CLK_NS      = 100;
   localparam int PERIOD_MS   = 10;
   localparam int PERIOD_CYC  = (PERIOD_MS * 1000000) / CLK_NS;
   localparam int BIT_KBPS    = 500;
   localparam int BIT_CYC     = 1000000 / (BIT_KBPS * CLK_NS);
   localparam int PER_W       = 24;
   localparam int DIV_W       = 5;
   // -------------------------------------------------
   // identifiers and lengths
   // -------------------------------------------------
   localparam logic [10:0] ID_DRV_BASE = 11'h400;
   localparam logic [10:0] ID_VI       = 11'h408;
   localparam logic [10:0] ID_IC       = 11'h409;
   localparam logic [10:0] ID_LOG      = 11'h40A;
   localparam logic [10:0] ID_ERR_BASE = 11'h420;
   localparam logic [10:0] ID_ERR_LAST = 11'h42A;
   localparam int          N_DRV       = 8;
   localparam int          N_PER       = 11;
   localparam int          N_ERR       = 11;
   localparam logic [4:0]  SLOT_LAST   = 5'h15;
   localparam logic [3:0]  FRM_DLC     = 4'h8;
   localparam logic [1:0]  BUF_DEPTH   = 2'h2;
   // -------------------------------------------------
   // drive status byte and input word
   // -------------------------------------------------
   localparam int DS_ACT   = 4;
   localparam int DS_IND   = 5;
   localparam int DS_SHR   = 6;
   localparam int DS_ALIVE = 7;
   localparam int IN_W     = 11;
   localparam int IN_INACT = 11;
   localparam int IN_PBRK  = 12;
   localparam int IN_CLUT  = 13;
   localparam int IN_ECON  = 14;
   localparam int IN_EACT  = 15;
   // input device type codes
   localparam logic [3:0] DT_EVAL     = 4'h0;
   localparam logic [3:0] DT_GB_LEVER = 4'h2;
   localparam logic [3:0] DT_GB_JOY   = 4'h4;
   localparam logic [3:0] DT_ST_JOY   = 4'h6;
   localparam logic [3:0] DT_ST_WHEEL = 4'h8;
   localparam logic [3:0] DT_UNUSED   = 4'h9;
   localparam logic [3:0] DT_NC       = 4'hA;
   // vehicle interface status bits
   localparam int VS_PRESENT = 0;
   localparam int VS_BOOTED  = 1;
   localparam int VS_COIL    = 2;
   localparam int VS_BRAKE   = 3;
   localparam int VS_PARK    = 4;
   localparam int VS_ENGAGED = 5;
   localparam int VS_OFFSW   = 6;
   localparam int VS_IGN     = 7;
   localparam int AUX_CLUTCH = 0;
   // information centre, error record and logger status bits
   localparam int IS_PRESENT = 0;
   localparam int IS_BOOTED  = 1;
   localparam int IS_TEST    = 2;
   localparam int IS_REQ_LO  = 4;
   localparam int ES_NEW     = 0;
   localparam int LS_PRESENT = 0;
   // -------------------------------------------------
   // state
   // -------------------------------------------------
   typedef enum logic {CST_IDLE, CST_SCAN} cst_fsm_t;
   typedef struct packed {
      cst_fsm_t          fsm;
      logic [4:0]        idx;
      logic              pend;
      logic [PER_W-1:0]  per;
      logic [DIV_W-1:0]  bdiv;
      logic [1:0]        cnt;
      logic [1:0][10:0]  id;
      logic [1:0][63:0]  dat;
   } cst_state_t;
endpackage : cst_pkg

// ### design/cst_broadcast.sv
// periodic and error status frame generator feeding a can controller
`timescale 1ns/1ps
module cst_broadcast import cst_pkg::*; #(
   parameter int PERIOD = PERIOD_CYC
) (
   // clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       reset,
   // drive modules
   input  wire logic [N_DRV-1:0][3:0]      drv_type,
   input  wire logic [N_DRV-1:0]           drv_active,
   input  wire logic [N_DRV-1:0]           drv_ind_err,
   input  wire logic [N_DRV-1:0]           drv_shr_err,
   input  wire logic [N_DRV-1:0]           drv_alive,
   input  wire logic [N_DRV-1:0][15:0]     drv_encoder,
   input  wire logic [N_DRV-1:0][IN_W-1:0] drv_input,
   input  wire logic [N_DRV-1:0]           drv_req_inact,
   input  wire logic [N_DRV-1:0]           drv_pbrake_req,
   input  wire logic [N_DRV-1:0]           drv_clutch_req,
   input  wire logic [N_DRV-1:0]           drv_eval_conn,
   input  wire logic [N_DRV-1:0]           drv_eval_act,
   input  wire logic [N_DRV-1:0][15:0]     drv_data,
   input  wire logic [N_DRV-1:0][7:0]      drv_cmd,
   // vehicle interface
   input  wire logic [7:0]                 vi_status,
   input  wire logic [7:0]                 vi_speed_mph,
   input  wire logic [7:0]                 aux_flag_byte,
   input  wire logic [15:0]                generic_word_a,
   input  wire logic [7:0]                 first_battery_level,
   input  wire logic [7:0]                 second_battery_level,
   input  wire logic [7:0]                 vi_cmd,
   // information centre
   input  wire logic [7:0]                 ic_cmd,
   input  wire logic [15:0]                ic_word_a,
   input  wire logic [15:0]                ic_word_b,
   input  wire logic [7:0]                 ic_char,
   input  wire logic [7:0]                 ic_drive,
   input  wire logic [7:0]                 ic_status,
   // logger
   input  wire logic                       lg_present,
   input  wire logic [15:0]                lg_x_accel,
   input  wire logic [15:0]                lg_y_accel,
   input  wire logic [15:0]                lg_data,
   input  wire logic [7:0]                 lg_cmd,
   // fault records
   input  wire logic [N_ERR-1:0]           err_active,
   input  wire logic [N_ERR-1:0][7:0]      err_type,
   input  wire logic [N_ERR-1:0][15:0]     err_hour,
   input  wire logic [N_ERR-1:0][7:0]      err_minute,
   input  wire logic [N_ERR-1:0][7:0]      err_count,
   input  wire logic [N_ERR-1:0][7:0]      err_drv_type,
   input  wire logic [N_ERR-1:0]           err_new,
   // frame stream to can controller
   output logic                            frm_valid,
   input  wire logic                       frm_ready,
   output logic [10:0]                     frm_id,
   output logic                            frm_ide,
   output logic [3:0]                      frm_dlc,
   output logic [63:0]                     frm_data,
   output logic                            can_bit_en,
   output logic                            period_busy
);
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   function automatic logic [10:0] slot_id(input logic [10:0] base, input logic [3:0] n);
      slot_id = base + {7'h00, n};
   endfunction : slot_id

   localparam logic [PER_W-1:0] PER_TOP = PER_W'(PERIOD - 1);
   localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(BIT_CYC - 1);

   cst_state_t  st_ff;
   cst_state_t  nxt_st;
   logic        tick;
   logic        pop;
   logic        psh;
   logic        want;
   logic [1:0]  wpos;
   logic [2:0]  d;
   logic [3:0]  e;
   logic [10:0] pid;
   logic [63:0] pdat;

   // ------------------------------------------------
   // next state
   // ------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      psh    = 1'b0;
      pid    = 11'h000;
      pdat   = 64'h0;
      d      = st_ff.idx[2:0];
      e      = 4'(st_ff.idx - 5'(N_PER));
      tick   = (st_ff.per == '0);
      pop    = (st_ff.cnt != 2'h0) && frm_ready;
      nxt_st.per  = tick ? PER_TOP : st_ff.per - 1'b1;
      nxt_st.bdiv = (st_ff.bdiv == '0) ? DIV_TOP : st_ff.bdiv - 1'b1;
      if (tick) begin
         nxt_st.pend = 1'b1;
      end
      // payload, byte 0 in bits 7:0, 16-bit fields low byte first
      if (st_ff.idx < 5'(N_DRV)) begin
         pid  = slot_id(ID_DRV_BASE, st_ff.idx[3:0]);
         pdat = {drv_cmd[d], drv_data[d],
                 drv_eval_act[d], drv_eval_conn[d], drv_clutch_req[d],
                 drv_pbrake_req[d], drv_req_inact[d], drv_input[d],
                 drv_encoder[d],
                 drv_alive[d], drv_shr_err[d], drv_ind_err[d],
                 drv_active[d], drv_type[d]};
      end else if (st_ff.idx == 5'(N_DRV)) begin
         pid  = ID_VI;
         pdat = {vi_cmd, second_battery_level, first_battery_level,
                 generic_word_a, aux_flag_byte,
                 vi_speed_mph, vi_status};
      end else if (st_ff.idx == 5'(N_DRV + 1)) begin
         pid  = ID_IC;
         pdat = {ic_status, ic_drive, ic_char, ic_word_b,
                 ic_word_a, ic_cmd};
      end else if (st_ff.idx == 5'(N_DRV + 2)) begin
         pid  = ID_LOG;
         pdat = {lg_cmd, lg_data, lg_y_accel, lg_x_accel,
                 7'h00, lg_present};
      end else begin
         pid  = slot_id(ID_ERR_BASE, e);
         pdat = {8'h00, 7'h00, err_new[e], err_drv_type[e],
                 err_count[e], err_minute[e], err_hour[e], err_type[e]};
      end
      // error slots are skipped unless their fault stands
      want = (st_ff.idx < 5'(N_PER)) || ((e < 4'(N_ERR)) && err_active[e]);
      case (st_ff.fsm)
         CST_IDLE: begin
            if (st_ff.pend) begin
               nxt_st.fsm  = CST_SCAN;
               nxt_st.idx  = 5'h00;
               nxt_st.pend = tick;
            end
         end
         CST_SCAN: begin
            if (!want || st_ff.cnt != BUF_DEPTH) begin
               psh = want;
               if (st_ff.idx == SLOT_LAST) begin
                  nxt_st.fsm = CST_IDLE;
               end else begin
                  nxt_st.idx = st_ff.idx + 5'h01;
               end
            end
         end
         default: begin
            nxt_st.fsm = CST_IDLE;
         end
      endcase
      // two-entry buffer, slot 0 is the head
      wpos = st_ff.cnt - {1'b0, pop};
      if (pop) begin
         nxt_st.id[0]  = st_ff.id[1];
         nxt_st.dat[0] = st_ff.dat[1];
      end
      if (psh) begin
         nxt_st.id[wpos[0]]  = pid;
         nxt_st.dat[wpos[0]] = pdat;
      end
      nxt_st.cnt = 2'(st_ff.cnt + {1'b0, psh} - {1'b0, pop});
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------
   // outputs; no receive input exists at all
   // ------------------------------------------------
   assign frm_valid   = (st_ff.cnt != 2'h0);
   assign frm_id      = st_ff.id[0];
   assign frm_ide     = 1'b0;
   assign frm_dlc     = FRM_DLC;
   assign frm_data    = st_ff.dat[0];
   assign can_bit_en  = (st_ff.bdiv == '0);
   assign period_busy = (st_ff.fsm == CST_SCAN);

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_period_reload: assert property (tick |=> st_ff.per == PER_TOP)
      else $error("period counter not reloaded");
   a_round_start: assert property (st_ff.fsm == CST_IDLE && st_ff.pend |=>
      st_ff.fsm == CST_SCAN && st_ff.idx == 5'h00)
      else $error("round did not start");
   a_err_gated: assert property (psh && st_ff.idx >= 5'(N_PER) |->
      err_active[e] && pid >= ID_ERR_BASE && pid <= ID_ERR_LAST)
      else $error("error frame without fault");
   a_std_ident: assert property (frm_valid |-> !frm_ide && frm_id < 11'h430)
      else $error("bad identifier");
   a_drive_id: assert property (psh && st_ff.idx < 5'(N_DRV) |->
      pid[3:0] == st_ff.idx[3:0] && pdat[3:0] == drv_type[d])
      else $error("drive id or type wrong");
   a_drive_flags: assert property (psh && st_ff.idx < 5'(N_DRV) |->
      pdat[DS_ALIVE] == drv_alive[d] && pdat[DS_ACT] == drv_active[d])
      else $error("drive status bits wrong");
   a_enc_input: assert property (psh && st_ff.idx < 5'(N_DRV) |=>
      st_ff.dat[st_ff.cnt - 2'h1][18:8] == $past(drv_encoder[d][10:0]))
      else $error("encoder not stored low first");
   a_vi_speed: assert property (psh && pid == ID_VI |=>
      st_ff.dat[st_ff.cnt - 2'h1][15:8] == $past(vi_speed_mph))
      else $error("speed byte misplaced");
   a_hold_stall: assert property (frm_valid && !frm_ready |=>
      frm_valid && $stable(frm_id) && $stable(frm_data))
      else $error("frame lost under stall");
   a_buf_bound: assert property (st_ff.cnt <= BUF_DEPTH)
      else $error("buffer overfilled");

   // drive frame packing
   a_drive_errs: assert property (psh && st_ff.idx < 5'(N_DRV) |->
      pdat[DS_IND] == drv_ind_err[d] && pdat[DS_SHR] == drv_shr_err[d])
      else $error("drive error bits wrong");
   a_input_read: assert property (psh && st_ff.idx < 5'(N_DRV) |->
      pdat[24 +: IN_W] == drv_input[d])
      else $error("input reading misplaced");
   a_input_flags: assert property (psh && st_ff.idx < 5'(N_DRV) |->
      pdat[24 + IN_INACT] == drv_req_inact[d] && pdat[24 + IN_PBRK] == drv_pbrake_req[d] &&
      pdat[24 + IN_CLUT] == drv_clutch_req[d] && pdat[24 + IN_ECON] == drv_eval_conn[d] &&
      pdat[24 + IN_EACT] == drv_eval_act[d])
      else $error("input flag bits wrong");
   a_data_cmd: assert property (psh && st_ff.idx < 5'(N_DRV) |->
      pdat[55:40] == drv_data[d] && pdat[63:56] == drv_cmd[d])
      else $error("data word or command misplaced");

   // other frame packing
   a_vi_status: assert property (psh && pid == ID_VI |->
      pdat[7:0] == vi_status && pdat[16 + AUX_CLUTCH] == aux_flag_byte[AUX_CLUTCH])
      else $error("vehicle status bytes misplaced");
   a_vi_battery: assert property (psh && pid == ID_VI |->
      pdat[47:40] == first_battery_level && pdat[55:48] == second_battery_level)
      else $error("battery bytes misplaced");
   a_ic_status: assert property (psh && pid == ID_IC |->
      pdat[63:56] == ic_status && pdat[7:0] == ic_cmd)
      else $error("info centre bytes misplaced");
   a_log_layout: assert property (psh && pid == ID_LOG |->
      pdat[7:0] == {7'h00, lg_present} &&
      pdat[23:8] == lg_x_accel && pdat[39:24] == lg_y_accel)
      else $error("logger fields misplaced");
   a_err_layout: assert property (psh && st_ff.idx >= 5'(N_PER) |->
      pdat[7:0] == err_type[e] &&
      pdat[23:8] == err_hour[e] && pdat[48 + ES_NEW] == err_new[e])
      else $error("error frame fields misplaced");

   // timing and flow
   a_period_step: assert property (!tick |=>
      st_ff.per == $past(st_ff.per) - 1'b1)
      else $error("period counter skipped");
   a_bit_reload: assert property (can_bit_en |=>
      st_ff.bdiv == DIV_TOP && !can_bit_en)
      else $error("bit divider not reloaded");
   a_bit_step: assert property (!can_bit_en |=>
      st_ff.bdiv == $past(st_ff.bdiv) - 1'b1)
      else $error("bit divider skipped");
   a_full_hold: assert property (st_ff.cnt == BUF_DEPTH |->
      !psh)
      else $error("push into full buffer");
   a_idle_quiet: assert property (st_ff.fsm == CST_IDLE |->
      !psh)
      else $error("frame pushed outside a round");
   a_skip_slot: assert property (st_ff.fsm == CST_SCAN &&
      st_ff.idx >= 5'(N_PER) && !err_active[e] |-> !psh)
      else $error("error frame for absent fault");
   a_round_end: assert property (psh && st_ff.idx == SLOT_LAST |=>
      st_ff.fsm == CST_IDLE)
      else $error("round did not end");

   c_err_sent: cover property (psh && st_ff.idx >= 5'(N_PER));
   c_err_new: cover property (psh && st_ff.idx >= 5'(N_PER) && err_new[e]);
   c_stall_full: cover property (st_ff.cnt == BUF_DEPTH && !frm_ready);
   c_round_done: cover property (st_ff.fsm == CST_SCAN ##1 st_ff.fsm == CST_IDLE);
   c_tick_busy: cover property (tick && st_ff.fsm == CST_SCAN);
endmodule : cst_broadcast

// ### bench/cst_can_rx.sv
// listening can controller model on the frame stream
`timescale 1ns/1ps
module cst_can_rx (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // frame stream
   input  wire logic        frm_valid,
   output logic             frm_ready,
   input  wire logic [10:0] frm_id,
   input  wire logic        frm_ide,
   input  wire logic [3:0]  frm_dlc,
   input  wire logic [63:0] frm_data,
   // bench control
   input  wire logic        stall
);
   logic [10:0] got_id[$];
   logic [63:0] got_dat[$];
   logic [4:0]  got_fmt[$];
   int          got_t[$];
   logic [10:0] last_in;
   int          cyc = 0;
   // ready shows only willingness; nothing goes back toward control
   assign frm_ready = ~stall;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (!reset && frm_valid && frm_ready) begin
         got_id.push_back(frm_id);
         got_dat.push_back(frm_data);
         got_fmt.push_back({frm_ide, frm_dlc});
         got_t.push_back(cyc);
         // upper five flag bits dropped before the reading is used
         if (frm_id < 11'h408) last_in <= frm_data[34:24];
      end
   end
endmodule : cst_can_rx

// ### bench/tb.sv
// self-checking bench for the status broadcaster
`timescale 1ns/1ps
module tb import cst_pkg::*;;
   localparam int PER = 60;
   logic                       clk_sys, reset, stall, lg_present;
   logic [N_DRV-1:0][3:0]      drv_type;
   logic [N_DRV-1:0]           drv_active, drv_ind_err, drv_shr_err, drv_alive;
   logic [N_DRV-1:0]           drv_req_inact, drv_pbrake_req, drv_clutch_req;
   logic [N_DRV-1:0]           drv_eval_conn, drv_eval_act;
   logic [N_DRV-1:0][15:0]     drv_encoder, drv_data;
   logic [N_DRV-1:0][IN_W-1:0] drv_input;
   logic [N_DRV-1:0][7:0]      drv_cmd;
   logic [7:0]                 vi_status, vi_speed_mph, aux_flag_byte, vi_cmd;
   logic [7:0]                 first_battery_level, second_battery_level;
   logic [7:0]                 ic_cmd, ic_char, ic_drive, ic_status, lg_cmd;
   logic [15:0]                generic_word_a, ic_word_a, ic_word_b;
   logic [15:0]                lg_x_accel, lg_y_accel, lg_data;
   logic [N_ERR-1:0]           err_active, err_new;
   logic [N_ERR-1:0][7:0]      err_type, err_minute, err_count, err_drv_type;
   logic [N_ERR-1:0][15:0]     err_hour;
   logic                       frm_valid, frm_ready, frm_ide, can_bit_en, period_busy;
   logic [10:0]                frm_id;
   logic [3:0]                 frm_dlc;
   logic [63:0]                frm_data;
   logic [3:0]                 codes [8];
   int                         fail_count = 0;
   int                         total_checks = 0;
   int                         t_prev = -1;

   cst_broadcast #(.PERIOD(PER)) dut_u (.*);
   cst_can_rx rx_u (.clk_sys(clk_sys), .reset(reset), .frm_valid(frm_valid),
      .frm_ready(frm_ready), .frm_id(frm_id), .frm_ide(frm_ide), .frm_dlc(frm_dlc),
      .frm_data(frm_data), .stall(stall));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic set_inputs(input logic [7:0] p);
      for (int k = 0; k < N_ERR; k++) begin
         if (k < N_DRV) begin
            drv_type[k] = codes[k];
            drv_encoder[k] = 16'h0200 ^ {p, 8'(k)};
            drv_input[k] = {p[2:0], 8'(k)};
            drv_data[k] = {8'(k), p};
            drv_cmd[k] = p + 8'(k);
         end
         err_type[k] = p + 8'(k);
         err_hour[k] = {8'(k), ~p};
         err_minute[k] = 8'(k);
         err_count[k] = p ^ 8'(k);
         err_drv_type[k] = 8'(k + 1);
      end
      {drv_active, drv_ind_err, drv_shr_err, drv_alive} = {p, ~p, p ^ 8'h0F, p ^ 8'hCC};
      {drv_req_inact, drv_pbrake_req, drv_clutch_req, drv_eval_conn, drv_eval_act} =
         {p, p ^ 8'h55, ~p, p ^ 8'hF0, p ^ 8'h3C};
      {vi_status, vi_speed_mph, aux_flag_byte, first_battery_level, second_battery_level,
         vi_cmd} = {p, 8'h57, ~p, 8'h88, 8'h7E, p ^ 8'hA5};
      {ic_cmd, ic_char, ic_drive, ic_status, lg_cmd} = {p, ~p, 8'h07, p ^ 8'h0F, 8'hC3};
      {generic_word_a, ic_word_a, ic_word_b, lg_x_accel, lg_y_accel, lg_data} = {6{p, ~p}};
      lg_present = p[0];
      err_new = {3'h0, p};
   endtask : set_inputs

   // payload laid out byte 0 first, 16-bit fields low byte first
   function automatic logic [63:0] exp_pay(input int s);
      logic [15:0] w;
      w = {drv_eval_act[s % N_DRV], drv_eval_conn[s % N_DRV], drv_clutch_req[s % N_DRV],
         drv_pbrake_req[s % N_DRV], drv_req_inact[s % N_DRV], drv_input[s % N_DRV]};
      if (s < N_DRV) return {drv_cmd[s], drv_data[s], w, drv_encoder[s], drv_alive[s],
         drv_shr_err[s], drv_ind_err[s], drv_active[s], drv_type[s]};
      if (s == 8) return {vi_cmd, second_battery_level, first_battery_level, generic_word_a,
         aux_flag_byte, vi_speed_mph, vi_status};
      if (s == 9) return {ic_status, ic_drive, ic_char, ic_word_b, ic_word_a, ic_cmd};
      if (s == 10) return {lg_cmd, lg_data, lg_y_accel, lg_x_accel, 7'h00, lg_present};
      return {8'h00, 7'h00, err_new[s - 11], err_drv_type[s - 11], err_count[s - 11],
         err_minute[s - 11], err_hour[s - 11], err_type[s - 11]};
   endfunction : exp_pay

   task automatic wait_busy(input logic lvl);
      for (int i = 0; i < 500 && period_busy !== lvl; i++) begin
         @(posedge clk_sys);
         #1;
      end
      if (period_busy !== lvl) begin
         fail_count++;
         report_and_stop();
      end
   endtask : wait_busy

   // one broadcast round; the receiver stalls for hold cycles at its start
   task automatic do_round(input logic [N_ERR-1:0] errs, input int hold);
      int q[$];
      int s;
      wait_busy(1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      err_active = errs;
      rx_u.got_id.delete();
      rx_u.got_dat.delete();
      rx_u.got_fmt.delete();
      rx_u.got_t.delete();
      stall = (hold > 0);
      wait_busy(1'b1);
      repeat (hold) @(posedge clk_sys);
      #1;
      stall = 1'b0;
      wait_busy(1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      for (int k = 0; k < 11; k++) q.push_back(k);
      for (int k = 0; k < N_ERR; k++) if (errs[k]) q.push_back(11 + k);
      chk(64'(rx_u.got_id.size()), 64'(q.size()));
      for (int i = 0; i < q.size() && i < rx_u.got_id.size(); i++) begin
         s = q[i];
         chk(64'(rx_u.got_id[i]), 64'(s < 11 ? ID_DRV_BASE + 11'(s) : ID_ERR_BASE + 11'(s - 11)));
         chk(rx_u.got_dat[i], exp_pay(s));
         chk(64'(rx_u.got_fmt[i]), 64'({1'b0, FRM_DLC}));
      end
      chk(64'(rx_u.last_in), 64'(drv_input[N_DRV-1]));
      if (hold == 0 && t_prev >= 0) chk(64'(rx_u.got_t[0] - t_prev), 64'(PER));
      t_prev = (hold == 0) ? rx_u.got_t[0] : -1;
   endtask : do_round

   // -------------------------------------------------
   // main sequence
   // -------------------------------------------------
   initial begin
      int n;
      codes = '{DT_EVAL, DT_GB_LEVER, DT_GB_JOY, DT_ST_JOY, DT_ST_WHEEL, DT_UNUSED, DT_NC,
         DT_EVAL};
      reset = 1'b1;
      stall = 1'b0;
      err_active = '0;
      set_inputs(8'h00);
      repeat (20) @(posedge clk_sys);
      #1;
      chk(64'({frm_valid, period_busy}), 64'h0);
      reset = 1'b0;
      n = 0;
      for (int i = 0; i < 200; i++) begin
         @(posedge clk_sys);
         #1;
         n += can_bit_en;
      end
      chk(64'(n), 64'hA);
      set_inputs(8'h5A);
      do_round('0, 0);
      do_round('0, 0);
      set_inputs(8'hC3);
      do_round(11'h401, 12);
      do_round(11'h7FF, 20);
      do_round('0, 0);
      report_and_stop();
   end
endmodule : tb
